// File: serial_flash_buffer_commands.sv
// Command logic for the SRAM and program buffer paths of a serial flash.
// Assumes an SPI host on i_sck/i_cs_n/i_si and array logic on i_ref_clk
// that answers i_arr_data one cycle after o_arr_sector/o_arr_byte change.
`include "sfb_map.svh"

module serial_flash_buffer_commands #(
	parameter int PROG_CYCLES = `PROG_CYCLES
) (
	// Reference clock and reset
	input  wire logic        i_ref_clk,
	input  wire logic        i_reset,
	// SPI link
	input  wire logic        i_sck,
	input  wire logic        i_cs_n,
	input  wire logic        i_si,
	output logic             o_so,
	output logic             o_so_oe,
	// Array side
	input  wire logic [7:0]  i_arr_data,
	input  wire logic [8:0]  i_pbuf_addr,
	input  wire logic        i_write_enable,
	input  wire logic [8:0]  i_config_nv,
	output logic [15:0]      o_arr_sector,
	output logic [8:0]       o_arr_byte,
	output logic             o_arr_info,
	output logic [7:0]       o_pbuf_data,
	output logic             o_prog_start,
	output logic [15:0]      o_prog_sector,
	// Status and configuration
	output logic             o_busy,
	output logic             o_transfer_pending,
	output logic             o_compare_mismatch,
	output logic [8:0]       o_config
);

	sfb_pkg::ref_state_t  st;
	sfb_pkg::ref_state_t  next_st;
	sfb_pkg::link_state_t ln;
	sfb_pkg::link_state_t next_ln;

	logic [7:0] sram [0:`BUF_BYTES-1];
	logic [7:0] pbuf [0:`BUF_BYTES-1];
	logic       sram_we;
	logic [8:0] sram_wa;
	logic [7:0] sram_wd;
	logic       pbuf_we;
	logic [8:0] pbuf_wa;
	logic [7:0] pbuf_wd;

	// Received byte and its event toggle; not cleared by chip select so
	// the reference side can still fetch the last byte after the frame
	logic [7:0] rx_byte;
	logic       rx_tog;
	logic       so_neg;
	logic       oe_neg;
	logic       read_clock_edge_select;

	// Link domain, cleared whenever chip select is high
	always_comb begin
		next_ln = ln;
		next_ln.bitcnt = ln.bitcnt + 3'h1;
		next_ln.shin = {ln.shin[5:0], i_si};
		if (ln.bitcnt == 3'h7) begin
			// tx_hold and tx_oe were settled a full byte earlier
			next_ln.txsh = st.tx_hold;
			next_ln.oe = st.tx_oe;
		end else begin
			next_ln.txsh = {ln.txsh[6:0], 1'b0};
		end
	end

	always_ff @(posedge i_sck or posedge i_reset or posedge i_cs_n) begin
		if (i_reset || i_cs_n) begin
			ln <= '0;
		end else begin
			ln <= next_ln;
		end
	end

	always_ff @(posedge i_sck or posedge i_reset) begin
		if (i_reset) begin
			rx_byte <= 8'h00;
			rx_tog <= 1'b0;
		end else if (!i_cs_n && ln.bitcnt == 3'h7) begin
			rx_byte <= {ln.shin, i_si};
			rx_tog <= ~rx_tog;
		end
	end

	always_ff @(negedge i_sck or posedge i_reset or posedge i_cs_n) begin
		if (i_reset || i_cs_n) begin
			so_neg <= 1'b0;
			oe_neg <= 1'b0;
		end else begin
			so_neg <= ln.txsh[7];
			oe_neg <= ln.oe;
		end
	end

	// Config changes only at load and at chip-select rise, so it is static while frames run
	assign read_clock_edge_select = st.cfg[`CFG_RCE_BIT];
	// Edge select needs a mux after the flops; both paths are flops
	assign o_so = read_clock_edge_select ? ln.txsh[7] : so_neg;
	assign o_so_oe = read_clock_edge_select ? ln.oe : oe_neg;

	// Reference domain
	logic       tog_ev;
	logic       cs_rise;
	logic [3:0] idx;
	logic [4:0] pidx;
	logic       rd_ok;
	logic       wr_ok;
	logic [7:0] cmp_byte;
	logic [7:0] status_byte;
	logic [7:0] rb_byte;
	logic [15:0] rb_word;
	logic [7:0] sram_at;
	logic       can_start;

	always_comb begin
		next_st = st;
		sram_we = 1'b0;
		sram_wa = 9'h000;
		sram_wd = 8'h00;
		pbuf_we = 1'b0;
		pbuf_wa = 9'h000;
		pbuf_wd = 8'h00;
		idx = st.cnt;
		pidx = {1'b0, st.cnt} + 5'h02;
		tog_ev = st.tog_sync[2] ^ st.tog_sync[1];
		cs_rise = st.cs_sync[1] & ~st.cs_sync[2];
		sram_at = sram[st.baddr];
		cmp_byte = ~(i_arr_data ^ sram_at);
		status_byte = 8'h00;
		status_byte[`ST_BUSY_BIT] = st.busy;
		status_byte[`ST_XFER_BIT] = st.tr;
		status_byte[`ST_WREN_BIT] = i_write_enable;
		status_byte[`ST_CMP_BIT] = st.mismatch;
		rb_word = st.busy ? `RB_BUSY : `RB_IDLE;
		rb_byte = (pidx == `IDX_RB_HI) ? rb_word[15:8] : rb_word[7:0];
		case (st.op)
			`OP_SRAM_READ, `OP_COMPARE: rd_ok = !st.tr;
			`OP_PBUF_READ:              rd_ok = !st.tr && !st.busy;
			`OP_INFO_READ, `OP_CFG_READ, `OP_STATUS_READ: rd_ok = 1'b1;
			default:                    rd_ok = 1'b0;
		endcase
		wr_ok = !st.tr && (st.op == `OP_SRAM_WRITE ||
			(st.op == `OP_SECTOR_TO_SRAM && !st.busy));
		can_start = st.phase == sfb_pkg::PH_IDLE && !st.tr;
		next_st.prog_start = 1'b0;
		next_st.cs_sync = {st.cs_sync[1:0], i_cs_n};
		next_st.tog_sync = {st.tog_sync[1:0], rx_tog};
		next_st.pbuf_q = pbuf[i_pbuf_addr];
		if (st.busy_cnt != 21'h000000) begin
			next_st.busy_cnt = st.busy_cnt - 21'h000001;
		end
		if (st.tr_cnt != 10'h000) begin
			next_st.tr_cnt = st.tr_cnt - 10'h001;
		end

		case (st.phase)
			sfb_pkg::PH_LOAD: begin
				// Non-volatile setting caught after reset release
				next_st.cfg = i_config_nv;
				next_st.phase = sfb_pkg::PH_IDLE;
			end
			sfb_pkg::PH_COPY: begin
				// One byte a cycle; on buffer transfers the transfer time covers all 264, on a program only the busy time does
				if (st.copy_dir) begin
					sram_we = 1'b1;
					sram_wa = st.copy_idx;
					sram_wd = pbuf[st.copy_idx];
				end else begin
					pbuf_we = 1'b1;
					pbuf_wa = st.copy_idx;
					pbuf_wd = sram[st.copy_idx];
				end
				next_st.copy_idx = st.copy_idx + 9'h001;
				if (st.copy_idx == `LAST_BYTE) begin
					next_st.phase = sfb_pkg::PH_IDLE;
				end
			end
			sfb_pkg::PH_IDLE: begin
			end
			default: begin
				next_st.phase = sfb_pkg::PH_IDLE;
			end
		endcase

		if (tog_ev) begin
			if (st.cnt != 4'hF) begin
				next_st.cnt = st.cnt + 4'h1;
			end
			case (idx)
				4'h0: next_st.op = rx_byte;
				4'h1: next_st.field[15:8] = rx_byte;
				4'h2: next_st.field[7:0] = rx_byte;
				`IDX_BADDR_HI: next_st.baddr[8] = rx_byte[0];
				`IDX_BADDR_LO: next_st.baddr[7:0] = rx_byte;
				default: begin
				end
			endcase
			if (idx >= `IDX_DATA_WR && wr_ok) begin
				sram_we = 1'b1;
				sram_wa = st.baddr;
				// Sector bytes replace the host's input bytes
				sram_wd = (st.op == `OP_SECTOR_TO_SRAM) ?
					i_arr_data : rx_byte;
				next_st.baddr = (st.baddr == `LAST_BYTE) ?
					9'h000 : st.baddr + 9'h001;
			end
			next_st.tx_oe = 1'b0;
			if (rd_ok && pidx >= `IDX_RB_HI) begin
				next_st.tx_oe = 1'b1;
				next_st.tx_hold = rb_byte;
			end
			if (rd_ok && pidx >= `IDX_DATA_RD) begin
				case (st.op)
					`OP_CFG_READ: begin
						next_st.tx_hold = 8'h00;
						if (pidx == `IDX_DATA_RD) begin
							next_st.tx_hold = {7'h00, st.cfg[8]};
						end else if (pidx == `IDX_CFG_LO) begin
							next_st.tx_hold = st.cfg[7:0];
						end
					end
					`OP_STATUS_READ: begin
						next_st.tx_hold = (pidx == `IDX_DATA_RD) ?
							status_byte : 8'h00;
					end
					default: begin
						if (st.op == `OP_SRAM_READ) begin
							next_st.tx_hold = sram[st.baddr];
						end else if (st.op == `OP_PBUF_READ) begin
							next_st.tx_hold = pbuf[st.baddr];
						end else if (st.op == `OP_COMPARE) begin
							next_st.tx_hold = cmp_byte;
							if (cmp_byte != 8'hFF) begin
								next_st.mismatch = 1'b1;
							end
						end else begin
							next_st.tx_hold = i_arr_data;
						end
						next_st.baddr = (st.baddr == `LAST_BYTE) ?
							9'h000 : st.baddr + 9'h001;
					end
				endcase
			end
		end

		if (cs_rise) begin
			// Short frames fall through with no effect
			case (next_st.op)
				`OP_SRAM_TO_SECTOR: begin
					if (next_st.cnt >= `MIN_CNT_FIELD && can_start &&
						!st.busy && i_write_enable) begin
						next_st.busy_cnt = 21'(PROG_CYCLES);
						next_st.prog_start = 1'b1;
						next_st.prog_sector = next_st.field;
						next_st.phase = sfb_pkg::PH_COPY;
						next_st.copy_dir = 1'b0;
						next_st.copy_idx = 9'h000;
					end
				end
				`OP_SRAM_TO_PBUF, `OP_PBUF_TO_SRAM: begin
					if (next_st.cnt >= `MIN_CNT_XFER && can_start &&
						(next_st.op == `OP_SRAM_TO_PBUF ||
						!st.busy)) begin
						next_st.tr_cnt = 10'(`XFER_CYCLES);
						next_st.phase = sfb_pkg::PH_COPY;
						next_st.copy_dir = next_st.op == `OP_PBUF_TO_SRAM;
						next_st.copy_idx = 9'h000;
					end
				end
				`OP_CFG_WRITE: begin
					if (next_st.cnt >= `MIN_CNT_FIELD && !st.busy) begin
						next_st.cfg = next_st.field[`CFG_BITS-1:0];
						next_st.busy_cnt = 21'(PROG_CYCLES);
					end
				end
				`OP_CLEAR_CMP: begin
					if (next_st.cnt >= `MIN_CNT_SHORT) begin
						next_st.mismatch = 1'b0;
					end
				end
				default: begin
				end
			endcase
			next_st.cnt = 4'h0;
			next_st.op = 8'h00;
			next_st.tx_oe = 1'b0;
		end
		next_st.busy = next_st.busy_cnt != 21'h000000;
		next_st.tr = next_st.tr_cnt != 10'h000;
	end

	always_ff @(posedge i_ref_clk or posedge i_reset) begin
		if (i_reset) begin
			st <= '0;
			st.phase <= sfb_pkg::PH_LOAD;
			st.cs_sync <= 3'h7;
		end else begin
			st <= next_st;
		end
	end

	// Buffers keep their contents until overwritten
	always_ff @(posedge i_ref_clk) begin
		if (sram_we) begin
			sram[sram_wa] <= sram_wd;
		end
		if (pbuf_we) begin
			pbuf[pbuf_wa] <= pbuf_wd;
		end
	end

	assign o_arr_sector = st.field;
	assign o_arr_byte = st.baddr;
	assign o_arr_info = st.op == `OP_INFO_READ;
	assign o_pbuf_data = st.pbuf_q;
	assign o_prog_start = st.prog_start;
	assign o_prog_sector = st.prog_sector;
	assign o_busy = st.busy;
	assign o_transfer_pending = st.tr;
	assign o_compare_mismatch = st.mismatch;
	assign o_config = st.cfg;

	AST_PROG_BUSY: assert property (
		@(posedge i_ref_clk) disable iff (i_reset)
		st.prog_start |-> st.busy [*8])
		else $error("busy not held after program start");

	AST_XFER_FLAG: assert property (
		@(posedge i_ref_clk) disable iff (i_reset)
		$rose(st.phase == sfb_pkg::PH_COPY) && !st.prog_start
		|-> st.tr throughout (##[0:264] st.phase == sfb_pkg::PH_IDLE))
		else $error("transfer flag dropped during copy");

	AST_CMP_STICKY: assert property (
		@(posedge i_ref_clk) disable iff (i_reset)
		st.mismatch && !(cs_rise && st.op == `OP_CLEAR_CMP)
		|=> st.mismatch)
		else $error("mismatch flag lost without clear");

	AST_CMP_CLEAR: assert property (
		@(posedge i_ref_clk) disable iff (i_reset)
		cs_rise && st.op == `OP_CLEAR_CMP && st.cnt >= 4'h3
		&& !tog_ev |=> !st.mismatch)
		else $error("clear did not reset mismatch");

	AST_RB_VALUE: assert property (
		@(posedge i_ref_clk) disable iff (i_reset)
		tog_ev && !cs_rise && rd_ok && pidx == 5'h07
		|=> st.tx_hold == ($past(st.busy) ? 8'h66 : 8'h99))
		else $error("ready/busy byte wrong");

	AST_NO_DRIVE_COPY: assert property (
		@(posedge i_ref_clk) disable iff (i_reset)
		st.op == `OP_SECTOR_TO_SRAM |-> !st.tx_oe)
		else $error("output enabled during sector copy");

	AST_WRAP: assert property (
		@(posedge i_ref_clk) disable iff (i_reset)
		tog_ev && !cs_rise && wr_ok && st.cnt >= 4'h5
		&& st.baddr == 9'h107 |=> st.baddr == 9'h000)
		else $error("byte counter did not wrap");

	AST_CMP_BITS: assert property (
		@(posedge i_ref_clk) disable iff (i_reset)
		tog_ev && !cs_rise && rd_ok && st.op == `OP_COMPARE && pidx >= 5'h09
		|=> (st.tx_hold ^ $past(i_arr_data)) == ~$past(sram_at))
		else $error("compare byte wrong");

	AST_SHORT_DROP: assert property (
		@(posedge i_ref_clk) disable iff (i_reset)
		cs_rise && !tog_ev && st.op == `OP_SRAM_TO_SECTOR
		&& st.cnt < 4'h5
		|=> !st.prog_start && $stable(st.phase))
		else $error("short frame acted on");

	AST_PBUF_REFUSE: assert property (
		@(posedge i_ref_clk) disable iff (i_reset)
		st.op == `OP_PBUF_READ && st.busy |-> !rd_ok)
		else $error("program buffer read while busy");

	AST_CFG_BUSY: assert property (
		@(posedge i_ref_clk) disable iff (i_reset)
		cs_rise && !tog_ev && st.op == `OP_CFG_WRITE && st.cnt >= 4'h5
		&& !st.busy |=> st.busy ##1 st.busy)
		else $error("config write not busy");

endmodule : serial_flash_buffer_commands

// File: sfb_map.svh
// Constants of the serial buffer command block: opcodes, field positions,
// byte indices within a frame, status layout and timing counts.
// Assumes a 250 MHz reference clock and an SPI host as the other party.
`ifndef SFB_MAP_SVH
`define SFB_MAP_SVH

`define OP_SRAM_TO_SECTOR 8'hF3
`define OP_SECTOR_TO_SRAM 8'h54
`define OP_COMPARE        8'h86
`define OP_SRAM_WRITE     8'h82
`define OP_SRAM_READ      8'h81
`define OP_SRAM_TO_PBUF   8'h92
`define OP_PBUF_TO_SRAM   8'h55
`define OP_PBUF_READ      8'h91
`define OP_CFG_READ       8'h8B
`define OP_CFG_WRITE      8'h8A
`define OP_STATUS_READ    8'h83
`define OP_CLEAR_CMP      8'h89
`define OP_INFO_READ      8'h15

`define RB_IDLE           16'h9999
`define RB_BUSY           16'h6666
`define LAST_BYTE         9'h107
`define BUF_BYTES         264

// Byte indices within a frame, opcode at index 0
`define IDX_BADDR_HI      4'h3
`define IDX_BADDR_LO      4'h4
`define IDX_DATA_WR       4'h5
`define IDX_RB_HI         5'h07
`define IDX_RB_LO         5'h08
`define IDX_DATA_RD       5'h09
`define IDX_CFG_LO        5'h0A
`define MIN_CNT_SHORT     4'h3
`define MIN_CNT_FIELD     4'h5
`define MIN_CNT_XFER      4'h7

`define ST_BUSY_BIT       0
`define ST_XFER_BIT       1
`define ST_WREN_BIT       2
`define ST_CMP_BIT        3
`define CFG_RCE_BIT       0
`define CFG_BITS          9

`define REF_PERIOD_NS     4
`define PROG_TIME_NS      5000000
`define XFER_TIME_NS      2000
`define XFER_CYCLES       ((`XFER_TIME_NS + `REF_PERIOD_NS - 1) / `REF_PERIOD_NS)
`define PROG_CYCLES       ((`PROG_TIME_NS + `REF_PERIOD_NS - 1) / `REF_PERIOD_NS)

`endif

// File: sfb_pkg.sv
// Types of the serial buffer command block: phase enum and state records.
// Assumes sfb_map.svh supplies all numeric constants.
package sfb_pkg;

	typedef enum logic [2:0] {
		PH_LOAD = 3'b001,
		PH_IDLE = 3'b010,
		PH_COPY = 3'b100
	} phase_t;

	typedef struct packed {
		phase_t      phase;
		logic [7:0]  op;
		logic [3:0]  cnt;
		logic [15:0] field;
		logic [8:0]  baddr;
		logic [20:0] busy_cnt;
		logic [9:0]  tr_cnt;
		logic        busy;
		logic        tr;
		logic [8:0]  copy_idx;
		logic        copy_dir;
		logic        mismatch;
		logic [8:0]  cfg;
		logic        tx_oe;
		logic [7:0]  tx_hold;
		logic        prog_start;
		logic [15:0] prog_sector;
		logic [2:0]  cs_sync;
		logic [2:0]  tog_sync;
		logic [7:0]  pbuf_q;
	} ref_state_t;

	typedef struct packed {
		logic [2:0] bitcnt;
		logic [6:0] shin;
		logic [7:0] txsh;
		logic       oe;
	} link_state_t;

endpackage : sfb_pkg

// File: sfb_array_model.sv
// Array-side partner: sector and information contents as a pattern.
// Assumes the block expects a byte one reference cycle after an address.
module sfb_array_model (
	// Clock
	input  wire logic        i_clk,
	// Address from the block
	input  wire logic [15:0] i_sector,
	input  wire logic [8:0]  i_byte,
	input  wire logic        i_info,
	// Data back
	output logic [7:0]       o_data
);
	timeunit 1ns;
	timeprecision 1ps;

	// Registered, so a late address shows up as a wrong byte
	always_ff @(posedge i_clk) begin
		if (i_info) begin
			o_data <= i_byte[7:0] ^ 8'hA5;
		end else begin
			o_data <= i_byte[7:0] ^ i_sector[7:0];
		end
	end
endmodule : sfb_array_model

// File: serial_flash_buffer_commands_tb_top.sv
// Self-checking bench: SPI frames from tasks, array model on the side.
// Assumes a 4 ns reference clock and an 80 ns SCK that runs in frames only.
module serial_flash_buffer_commands_tb_top;
	timeunit 1ns;
	timeprecision 1ps;

	localparam int PROG = 5000;
	logic        i_ref_clk = 1'b0;
	logic        i_reset   = 1'b1;
	logic        sck       = 1'b0;
	logic        cs_n      = 1'b1;
	logic        si        = 1'b0;
	logic        we        = 1'b0;
	logic [8:0]  pbuf_addr = 9'h000;
	logic        so;
	logic        so_oe;
	logic [7:0]  arr_data;
	logic [15:0] arr_sector;
	logic [8:0]  arr_byte;
	logic        arr_info;
	logic [7:0]  pbuf_q;
	logic        ps;
	logic [15:0] psec;
	logic        busy;
	logic        tr;
	logic        mism;
	logic [8:0]  cfg;
	logic [7:0]  tx[32];
	logic [7:0]  rx[32];
	logic        oe_any;
	int          n_errors  = 0;
	int          cmp_count = 0;
	int          ps_cnt    = 0;
	logic [15:0] ps_sec    = 16'h0000;
	int          len;

	initial begin
		forever #2 i_ref_clk = ~i_ref_clk;
	end

	serial_flash_buffer_commands #(.PROG_CYCLES(PROG)) u_dut (
		.i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_sck(sck),
		.i_cs_n(cs_n), .i_si(si), .o_so(so), .o_so_oe(so_oe),
		.i_arr_data(arr_data), .i_pbuf_addr(pbuf_addr),
		.i_write_enable(we), .i_config_nv(9'h001),
		.o_arr_sector(arr_sector), .o_arr_byte(arr_byte),
		.o_arr_info(arr_info), .o_pbuf_data(pbuf_q),
		.o_prog_start(ps), .o_prog_sector(psec), .o_busy(busy),
		.o_transfer_pending(tr), .o_compare_mismatch(mism),
		.o_config(cfg)
	);

	sfb_array_model u_array (
		.i_clk(i_ref_clk), .i_sector(arr_sector), .i_byte(arr_byte),
		.i_info(arr_info), .o_data(arr_data)
	);

	// One pulse is expected per accepted program command; the falling
	// edge keeps the count clear of the update race
	always @(negedge i_ref_clk) begin
		if (ps === 1'b1) begin
			ps_cnt++;
			ps_sec = psec;
		end
	end

	task automatic conclude();
		$display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : conclude

	task automatic chk(input string what, input logic [15:0] exp,
		input logic [15:0] got);
		cmp_count++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	// Zero fields, as the host should send them
	task automatic setup(input logic [7:0] op, input logic [15:0] f1,
		input logic [15:0] f2);
		foreach (tx[i]) tx[i] = 8'h00;
		tx[0] = op;
		tx[1] = f1[15:8];
		tx[2] = f1[7:0];
		tx[3] = f2[15:8];
		tx[4] = f2[7:0];
	endtask : setup

	// SI changes with SCK low; SO is taken just before each rising edge
	task automatic frame(input int n);
		repeat (5) @(posedge i_ref_clk);
		#1 cs_n = 1'b0;
		oe_any = 1'b0;
		#40;
		for (int k = 0; k < n; k++) begin
			for (int b = 7; b >= 0; b--) begin
				si = tx[k][b];
				#40;
				// Undriven SO reads as its pull-up level
				rx[k][b] = (so_oe === 1'b1) ? so : 1'b1;
				oe_any = oe_any | (so_oe === 1'b1);
				sck = 1'b1;
				#40;
				sck = 1'b0;
			end
		end
		#40 cs_n = 1'b1;
		si = 1'b0;
	endtask : frame

	task automatic wait_span(input bit sel, input int lim, output int cnt);
		cnt = 0;
		// Sample 1 ns after each rising edge, where outputs are settled
		@(posedge i_ref_clk);
		#1;
		for (int i = 0; i < 20 && !(sel ? busy : tr); i++)
			#4;
		while ((sel ? busy : tr) === 1'b1 && cnt < lim) begin
			#4;
			cnt++;
		end
		if (cnt >= lim) begin
			n_errors++;
			conclude();
		end
	endtask : wait_span

	initial begin
		repeat (10) @(posedge i_ref_clk);
		#1 i_reset = 1'b0;
		repeat (6) @(posedge i_ref_clk);
		chk("config", 16'h0001, {7'h00, cfg});
		#1 we = 1'b1;
		setup(8'h83, 16'h0000, 16'h0000);
		frame(10);
		chk("rb idle", 16'h9999, {rx[7], rx[8]});
		chk("status", 16'h0004, {8'h00, rx[9]});
		setup(8'h82, 16'h0000, 16'h0107);
		tx[5] = 8'hA0;
		tx[6] = 8'hA1;
		frame(8);
		setup(8'h81, 16'h0000, 16'h0107);
		frame(11);
		chk("sram wrap", 16'hA0A1, {rx[9], rx[10]});
		// Copy across the wrap point, four bytes written
		setup(8'h54, 16'h0005, 16'h0107);
		frame(9);
		chk("copy oe", 16'h0000, {15'h0000, oe_any});
		setup(8'h81, 16'h0000, 16'h0107);
		frame(11);
		chk("copied", 16'h0205, {rx[9], rx[10]});
		setup(8'h86, 16'h0005, 16'h0107);
		frame(11);
		chk("cmp equal", 16'hFFFF, {rx[9], rx[10]});
		chk("no mism", 16'h0000, {15'h0000, mism});
		setup(8'h86, 16'h0006, 16'h0107);
		frame(11);
		chk("cmp diff", 16'hFCFC, {rx[9], rx[10]});
		chk("mism set", 16'h0001, {15'h0000, mism});
		setup(8'h89, 16'h0000, 16'h0000);
		frame(2);
		#20;
		chk("short clear", 16'h0001, {15'h0000, mism});
		frame(3);
		#20;
		chk("clear", 16'h0000, {15'h0000, mism});
		setup(8'h92, 16'h0000, 16'h0000);
		frame(7);
		wait_span(1'b0, 600, len);
		chk("xfer len", 16'h0001, {15'h0000, len >= 495 && len <= 505});
		@(posedge i_ref_clk);
		#1 pbuf_addr = 9'h107;
		repeat (2) @(posedge i_ref_clk);
		chk("pbuf", 16'h0002, {8'h00, pbuf_q});
		setup(8'h82, 16'h0000, 16'h0107);
		tx[5] = 8'h33;
		frame(7);
		setup(8'h55, 16'h0000, 16'h0000);
		frame(7);
		wait_span(1'b0, 600, len);
		chk("back len", 16'h0001, {15'h0000, len >= 495 && len <= 505});
		setup(8'h81, 16'h0000, 16'h0107);
		frame(10);
		chk("back", 16'h0002, {8'h00, rx[9]});
		setup(8'hF3, 16'h0007, 16'h0000);
		frame(3);
		#20;
		chk("short prog", 16'h0000, ps_cnt[15:0]);
		frame(7);
		repeat (10) @(posedge i_ref_clk);
		chk("prog pulses", 16'h0001, ps_cnt[15:0]);
		chk("prog sector", 16'h0007, ps_sec);
		chk("busy", 16'h0001, {15'h0000, busy});
		setup(8'h81, 16'h0000, 16'h0107);
		frame(10);
		chk("rb busy", 16'h6666, {rx[7], rx[8]});
		chk("sram busy", 16'h0002, {8'h00, rx[9]});
		setup(8'h91, 16'h0000, 16'h0107);
		frame(10);
		chk("pbuf refused", 16'h0000, {15'h0000, oe_any});
		wait_span(1'b1, 6000, len);
		frame(10);
		chk("pbuf read", 16'h0002, {8'h00, rx[9]});
		setup(8'h8B, 16'h0000, 16'h0000);
		frame(11);
		chk("cfg read", 16'h0001, {rx[9], rx[10]});
		setup(8'h8A, 16'h0000, 16'h0000);
		frame(5);
		repeat (10) @(posedge i_ref_clk);
		chk("cfg busy", 16'h0001, {15'h0000, busy});
		wait_span(1'b1, 6000, len);
		chk("cfg new", 16'h0000, {7'h00, cfg});
		// Falling-edge output must still meet the same sampling point
		setup(8'h81, 16'h0000, 16'h0107);
		frame(10);
		chk("fall edge", 16'h0002, {8'h00, rx[9]});
		setup(8'h15, 16'h0000, 16'h0003);
		frame(10);
		chk("info", 16'h00A6, {8'h00, rx[9]});
		conclude();
	end
endmodule : serial_flash_buffer_commands_tb_top
